// ==== hdl/rca_calendar.sv ====
`timescale 1ns/1ps
`include "rca_consts.svh"
// What this block does
// - hour advances on minute carry, both formats
// - written counters load within two ticks
// - write wins, carry dropped for written counter
// - format change converts current hour encoding
// - hour resets 12H, reads 00H in 24h
// - 12h bit five marks PM, noon 32H
// - day wraps at month length
// - year multiple of four is leap
// - weekday 0..6 advances with day
// - month 01..12 advances on day overflow
// - year 00..99 advances on month overflow
// - trim moves sub-second terminal count
// - interval bit picks correction seconds
// - direction lengthens or shortens by twice
// - zero magnitude bits five..one, no correction
// - illegal alarm minute or hour never matches
// - alarm hour same encoding, resets 12H/00H
// - match flag set one tick after match
// - hold stops hour..year counters from advancing; sub-second counter keeps running
module rca_calendar #(
   parameter int PADDR_W = 22,              // apb address width
   parameter int RTC_DIV = `RCA_RTC_DIV     // system clocks per operating tick
) (
   input  wire logic               clock_i,         // 50 MHz clock
   input  wire logic               reset_i,         // async reset, high
   input  wire logic               psel_i,          // apb select
   input  wire logic               penable_i,       // apb enable
   input  wire logic               pwrite_i,        // apb direction
   input  wire logic [PADDR_W-1:0] paddr_i,         // apb byte address
   input  wire logic [31:0]        pwdata_i,        // apb write data
   input  wire logic [3:0]         pstrb_i,         // apb byte strobes
   output logic                    pready_o,        // apb ready
   output logic [31:0]             prdata_o,        // apb read data
   output logic                    pslverr_o,       // apb error
   input  wire logic               minute_carry_i,  // minute counter overflow pulse
   input  wire logic [7:0]         seconds_i,       // seconds counter value
   input  wire logic [7:0]         minute_i,        // minute counter value
   output logic                    sec_carry_o,     // sub-second overflow pulse
   output logic                    rtc_tick_o,      // operating clock enable
   output logic                    counter_run_o,   // counter run
   output logic                    counter_hold_o,  // counter hold
   output logic                    clock_format_o,  // 24h format selected
   output logic                    alarm_match_o    // alarm match flag
);
   // refuse settings the logic cannot serve
   if (PADDR_W < 22 || RTC_DIV < 2 || RTC_DIV > 2047) begin : g_param_check
      $error("rca_calendar: bad parameter");
   end

   localparam logic [10:0] DIV_LAST = 11'(RTC_DIV - 1); // divider terminal

   rca_pkg::rca_state_t s;       // registered state
   rca_pkg::rca_state_t next_s;  // next state

   // bcd byte to binary
   function automatic logic [6:0] bcd2bin(input logic [7:0] v);
      return 7'(7'(v[7:4]) * 7'd10 + 7'(v[3:0]));
   endfunction

   // binary to bcd byte
   function automatic logic [7:0] bin2bcd(input logic [6:0] b);
      logic [6:0] tens;
      logic [6:0] ones;
      tens = b / 7'd10;
      ones = 7'(b - 7'(tens * 7'd10));
      return {tens[3:0], ones[3:0]};
   endfunction

   // both digits legal and value within max
   function automatic logic bcd_ok(input logic [7:0] v, input logic [6:0] max);
      return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (bcd2bin(v) <= max);
   endfunction

   // hour encoding to 0..23
   function automatic logic [6:0] hour_bin(input logic [7:0] h, input logic f24);
      logic [6:0] v;
      v = bcd2bin({3'h0, h[4:0]});
      if (f24) begin
         v = bcd2bin(h);
      end else begin
         if (v == 7'd12) begin
            v = 7'd0;                            // 12 a.m. is midnight
         end
         if (h[5]) begin
            v = 7'(v + 7'd12);                   // pm indicator
         end
      end
      return v;
   endfunction

   // 0..23 to hour encoding
   function automatic logic [7:0] hour_enc(input logic [6:0] b, input logic f24);
      logic [6:0] v;
      v = (b >= 7'd12) ? 7'(b - 7'd12) : b;
      if (v == 7'd0) begin
         v = 7'd12;                              // noon 32H, midnight 12H
      end
      if (f24) begin
         return bin2bcd(b);
      end
      return bin2bcd(v) | ((b >= 7'd12) ? 8'h20 : 8'h00);
   endfunction

   // legal hour for the format
   function automatic logic hour_ok(input logic [7:0] h, input logic f24);
      if (f24) begin
         return bcd_ok(h, 7'd23);
      end
      return (h[7:6] == 2'h0) && bcd_ok({3'h0, h[4:0]}, 7'd12) && (h[4:0] != 5'h0);
   endfunction

   // last day of the month in binary
   function automatic logic [6:0] month_last(input logic [7:0] m, input logic [7:0] y);
      logic [6:0] yb;
      yb = bcd2bin(y);
      if (m == 8'h02) begin
         return (yb[1:0] == 2'h0) ? 7'd29 : 7'd28;  // leap every fourth year, 00 too
      end
      if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
         return 7'd30;
      end
      return 7'd31;
   endfunction

   // read mux for one register index
   function automatic logic [7:0] rd_byte(input rca_pkg::rca_state_t st, input logic [19:0] idx);
      unique case (idx)
         `RCA_IDX_HOUR:     return st.hour;
         `RCA_IDX_WDAY:     return st.wday;
         `RCA_IDX_DAY:      return st.day;
         `RCA_IDX_MONTH:    return st.month;
         `RCA_IDX_YEAR:     return st.year;
         `RCA_IDX_TRIM:     return st.trim;
         `RCA_IDX_AL_MIN:   return st.al_min;
         `RCA_IDX_AL_HOUR:  return st.al_hour;
         `RCA_IDX_AL_WDAYS: return st.al_wdays;
         `RCA_IDX_CTRL:     return {2'h0, st.hold_ack, st.al_flag, st.fmt24, st.al_en, st.hold, st.run};
         default:           return 8'h00;
      endcase
   endfunction

   // address decode
   logic [19:0] idx;        // register index from address
   logic        hit;        // address maps to a register
   logic        wr_acc;     // write access phase
   always_comb begin
      idx = paddr_i[21:2];
      hit = (paddr_i[1:0] == 2'h0) && (paddr_i[PADDR_W-1:2] == (PADDR_W-2)'(idx));
      unique case (idx)
         `RCA_IDX_HOUR, `RCA_IDX_WDAY, `RCA_IDX_DAY, `RCA_IDX_MONTH, `RCA_IDX_YEAR,
         `RCA_IDX_TRIM, `RCA_IDX_AL_MIN, `RCA_IDX_AL_HOUR, `RCA_IDX_AL_WDAYS,
         `RCA_IDX_CTRL: ;
         default:       hit = 1'b0;
      endcase
      wr_acc = psel_i && penable_i && pwrite_i && hit && pstrb_i[0]; // low byte lane only
   end

   // alarm compare and trim terminal
   logic        al_match;   // alarm match this cycle
   logic        corr_sec;   // this second takes correction
   logic [15:0] term;       // terminal count of sub-second counter
   always_comb begin
      al_match = s.al_en
               && bcd_ok(s.al_min, 7'd59)
               && hour_ok(s.al_hour, s.fmt24)
               && (minute_i == s.al_min)
               && (s.hour == s.al_hour)              // same encoding as hour
               && (s.wday[2:0] <= 3'h6)
               && s.al_wdays[s.wday[2:0]];
      if (s.trim[`RCA_TRIM_IVL]) begin
         corr_sec = (seconds_i == 8'h00);
      end else begin
         corr_sec = (seconds_i == 8'h00) || (seconds_i == 8'h20) || (seconds_i == 8'h40);
      end
      term = `RCA_SUB_TERM;
      if (corr_sec && (s.trim[5:1] != 5'h0)) begin
         if (s.trim[`RCA_TRIM_DIR]) begin
            term = 16'(`RCA_SUB_TERM - {9'h0, 6'(~s.trim[5:0]) + 6'h1, 1'b0});
         end else begin
            term = 16'(`RCA_SUB_TERM + {9'h0, 6'(s.trim[5:0] - 6'h1), 1'b0});
         end
      end
   end

   // next state
   always_comb begin
      logic       cy;       // carry into the next counter
      logic [6:0] hb;       // hour in binary
      logic [7:0] fmt_v;    // written control byte
      cy    = 1'b0;
      hb    = 7'd0;
      fmt_v = pwdata_i[7:0];
      next_s           = s;
      next_s.tick      = 1'b0;
      next_s.sec_carry = 1'b0;
      // operating clock divider
      if (s.div == DIV_LAST) begin
         next_s.div  = 11'h0;
         next_s.tick = 1'b1;
      end else begin
         next_s.div = 11'(s.div + 11'h1);
      end
      // operating tick work
      if (s.tick) begin
         next_s.hold_ack = s.hold;
         // sub-second counter
         if (s.run) begin
            if (s.subsec >= term) begin
               next_s.subsec    = 16'h0;
               next_s.sec_carry = 1'b1;
            end else begin
               next_s.subsec = 16'(s.subsec + 16'h1);
            end
         end
         // carry used only when running and not held
         cy = s.carry_pend && s.run && !s.hold;
         if (cy) begin
            next_s.carry_pend = 1'b0;
         end
         // hour
         if (s.wr_pend[rca_pkg::RCA_C_HOUR]) begin
            next_s.hour = s.wr_data[rca_pkg::RCA_C_HOUR];
            cy = 1'b0;
         end else if (cy) begin
            hb = hour_bin(s.hour, s.fmt24);
            next_s.hour = hour_enc((hb >= 7'd23) ? 7'd0 : 7'(hb + 7'd1), s.fmt24);
            cy = (hb >= 7'd23);
         end
         // weekday follows the day increment
         if (s.wr_pend[rca_pkg::RCA_C_WDAY]) begin
            next_s.wday = s.wr_data[rca_pkg::RCA_C_WDAY];
         end else if (cy && !s.wr_pend[rca_pkg::RCA_C_DAY]) begin
            next_s.wday = (s.wday >= 8'h06) ? 8'h00 : 8'(s.wday + 8'h01);
         end
         // day
         if (s.wr_pend[rca_pkg::RCA_C_DAY]) begin
            next_s.day = s.wr_data[rca_pkg::RCA_C_DAY];
            cy = 1'b0;
         end else if (cy) begin
            if (bcd2bin(s.day) >= month_last(s.month, s.year)) begin
               next_s.day = 8'h01;
            end else begin
               next_s.day = bin2bcd(7'(bcd2bin(s.day) + 7'd1));
               cy = 1'b0;
            end
         end
         // month
         if (s.wr_pend[rca_pkg::RCA_C_MONTH]) begin
            next_s.month = s.wr_data[rca_pkg::RCA_C_MONTH];
            cy = 1'b0;
         end else if (cy) begin
            if (s.month >= 8'h12) begin
               next_s.month = 8'h01;
            end else begin
               next_s.month = bin2bcd(7'(bcd2bin(s.month) + 7'd1));
               cy = 1'b0;
            end
         end
         // year
         if (s.wr_pend[rca_pkg::RCA_C_YEAR]) begin
            next_s.year = s.wr_data[rca_pkg::RCA_C_YEAR];
         end else if (cy) begin
            next_s.year = (s.year >= 8'h99) ? 8'h00 : bin2bcd(7'(bcd2bin(s.year) + 7'd1));
         end
         next_s.wr_pend = 5'h0;
         // alarm match history
         next_s.match_q = al_match;
         next_s.match_d = s.match_q;
      end
      // a new minute carry wins over this tick's clear
      if (minute_carry_i) begin
         next_s.carry_pend = 1'b1;
      end
      // read data caught in the setup phase
      if (psel_i && !penable_i && !pwrite_i) begin
         next_s.prdata = {24'h0, hit ? rd_byte(s, idx) : 8'h00};
      end
      // register writes
      if (wr_acc) begin
         unique case (idx)
            `RCA_IDX_HOUR: begin
               next_s.wr_pend[rca_pkg::RCA_C_HOUR] = 1'b1;
               next_s.wr_data[rca_pkg::RCA_C_HOUR] = pwdata_i[7:0];
            end
            `RCA_IDX_WDAY: begin
               next_s.wr_pend[rca_pkg::RCA_C_WDAY] = 1'b1;
               next_s.wr_data[rca_pkg::RCA_C_WDAY] = pwdata_i[7:0];
            end
            `RCA_IDX_DAY: begin
               next_s.wr_pend[rca_pkg::RCA_C_DAY] = 1'b1;
               next_s.wr_data[rca_pkg::RCA_C_DAY] = pwdata_i[7:0];
            end
            `RCA_IDX_MONTH: begin
               next_s.wr_pend[rca_pkg::RCA_C_MONTH] = 1'b1;
               next_s.wr_data[rca_pkg::RCA_C_MONTH] = pwdata_i[7:0];
            end
            `RCA_IDX_YEAR: begin
               next_s.wr_pend[rca_pkg::RCA_C_YEAR] = 1'b1;
               next_s.wr_data[rca_pkg::RCA_C_YEAR] = pwdata_i[7:0];
            end
            `RCA_IDX_TRIM:     next_s.trim     = pwdata_i[7:0];
            `RCA_IDX_AL_MIN:   next_s.al_min   = pwdata_i[7:0];
            `RCA_IDX_AL_HOUR:  next_s.al_hour  = pwdata_i[7:0];
            `RCA_IDX_AL_WDAYS: next_s.al_wdays = {1'b0, pwdata_i[6:0]};
            `RCA_IDX_CTRL: begin
               next_s.run   = fmt_v[`RCA_CTL_RUN];
               next_s.hold  = fmt_v[`RCA_CTL_HOLD];
               next_s.al_en = fmt_v[`RCA_CTL_AL_EN];
               // format change re-encodes hour and a legal alarm hour
               if (fmt_v[`RCA_CTL_FMT24] != s.fmt24) begin
                  next_s.fmt24   = fmt_v[`RCA_CTL_FMT24];
                  next_s.hour    = hour_enc(hour_bin(next_s.hour, s.fmt24), fmt_v[`RCA_CTL_FMT24]);
                  if (hour_ok(s.al_hour, s.fmt24)) begin
                     next_s.al_hour = hour_enc(hour_bin(s.al_hour, s.fmt24), fmt_v[`RCA_CTL_FMT24]);
                  end
               end
               // flag clears on a written zero only
               if (!fmt_v[`RCA_CTL_AL_FLAG]) begin
                  next_s.al_flag = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // flag set one tick after the match, winning over a clear
      if (s.tick && s.al_en && s.match_q && !s.match_d) begin
         next_s.al_flag = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s          <= '0;
         s.hour     <= `RCA_RST_HOUR;
         s.wday     <= `RCA_RST_WDAY;
         s.day      <= `RCA_RST_DAY;
         s.month    <= `RCA_RST_MONTH;
         s.year     <= `RCA_RST_YEAR;
         s.trim     <= `RCA_RST_TRIM;
         s.al_min   <= `RCA_RST_AL_MIN;
         s.al_hour  <= `RCA_RST_AL_HOUR;
         s.al_wdays <= `RCA_RST_AL_WDAYS;
      end else begin
         s <= next_s;
      end
   end

   // apb answers and status outputs
   assign pready_o       = 1'b1;
   assign pslverr_o      = psel_i && penable_i && !hit;
   assign prdata_o       = s.prdata;
   assign sec_carry_o    = s.sec_carry;
   assign rtc_tick_o     = s.tick;
   assign counter_run_o  = s.run;
   assign counter_hold_o = s.hold;
   assign clock_format_o = s.fmt24;
   assign alarm_match_o  = s.al_flag;
endmodule

// ==== shared/rca_consts.svh ====
`ifndef RCA_CONSTS_SVH
`define RCA_CONSTS_SVH
// register indices; byte address is four times the index
`define RCA_IDX_HOUR      20'hFFF94
`define RCA_IDX_WDAY      20'hFFF95
`define RCA_IDX_DAY       20'hFFF96
`define RCA_IDX_MONTH     20'hFFF97
`define RCA_IDX_YEAR      20'hFFF98
`define RCA_IDX_TRIM      20'hFFF99
`define RCA_IDX_AL_MIN    20'hFFF9A
`define RCA_IDX_AL_HOUR   20'hFFF9B
`define RCA_IDX_AL_WDAYS  20'hFFF9C
`define RCA_IDX_CTRL      20'hFFFA0
// reset values
`define RCA_RST_HOUR      8'h12
`define RCA_RST_WDAY      8'h00
`define RCA_RST_DAY       8'h01
`define RCA_RST_MONTH     8'h01
`define RCA_RST_YEAR      8'h00
`define RCA_RST_TRIM      8'h00
`define RCA_RST_AL_MIN    8'h00
`define RCA_RST_AL_HOUR   8'h12
`define RCA_RST_AL_WDAYS  8'h00
// control register bit positions
`define RCA_CTL_RUN       0
`define RCA_CTL_HOLD      1
`define RCA_CTL_AL_EN     2
`define RCA_CTL_FMT24     3
`define RCA_CTL_AL_FLAG   4
`define RCA_CTL_HOLD_ACK  5
// trim register bit positions
`define RCA_TRIM_DIR      6
`define RCA_TRIM_IVL      7
// timing
`define RCA_SYS_HZ        50000000
`define RCA_RTC_HZ        32768
`define RCA_RTC_DIV       (`RCA_SYS_HZ / `RCA_RTC_HZ)
`define RCA_SUB_TERM      16'h7FFF
`endif

// ==== shared/rca_pkg.sv ====
package rca_pkg;
   // calendar counters in their order along the carry chain
   typedef enum logic [2:0] {
      RCA_C_HOUR  = 3'h0,
      RCA_C_WDAY  = 3'h1,
      RCA_C_DAY   = 3'h2,
      RCA_C_MONTH = 3'h3,
      RCA_C_YEAR  = 3'h4
   } rca_cnt_t;

   // whole state of the calendar block
   typedef struct packed {
      logic [10:0]      div;        // operating clock divider
      logic             tick;       // operating clock enable
      logic [15:0]      subsec;     // sub-second counter
      logic             sec_carry;  // sub-second overflow pulse
      logic [7:0]       hour;       // hour counter
      logic [7:0]       wday;       // weekday counter
      logic [7:0]       day;        // day counter
      logic [7:0]       month;      // month counter
      logic [7:0]       year;       // year counter
      logic [4:0]       wr_pend;    // buffered write waiting
      logic [4:0][7:0]  wr_data;    // buffered write values
      logic [7:0]       trim;       // drift trim
      logic [7:0]       al_min;     // alarm minute
      logic [7:0]       al_hour;    // alarm hour
      logic [7:0]       al_wdays;   // alarm weekday mask
      logic             run;        // counter run
      logic             hold;       // counter hold
      logic             hold_ack;   // hold in effect
      logic             al_en;      // alarm compare enable
      logic             fmt24;      // clock format select
      logic             al_flag;    // alarm match flag
      logic             match_q;    // match at last tick
      logic             match_d;    // match one tick earlier
      logic             carry_pend; // minute carry not yet used
      logic [31:0]      prdata;     // read data
   } rca_state_t;
endpackage

// ==== test/rca_calendar_assertions.sv ====
`timescale 1ns/1ps
`include "rca_consts.svh"
// port checks of the calendar block
module rca_calendar_assertions #(
   parameter int PADDR_W = 22, // apb address width
   parameter int RTC_DIV = 4   // clocks per tick
) (
   input wire logic               clock_i,        // clock
   input wire logic               reset_i,        // reset
   input wire logic               psel_i,         // select
   input wire logic               penable_i,      // enable
   input wire logic               pwrite_i,       // direction
   input wire logic [PADDR_W-1:0] paddr_i,        // address
   input wire logic [31:0]        pwdata_i,       // write data
   input wire logic [3:0]         pstrb_i,        // strobes
   input wire logic               pready_o,       // ready
   input wire logic [31:0]        prdata_o,       // read data
   input wire logic               pslverr_o,      // error
   input wire logic               minute_carry_i, // minute carry
   input wire logic [7:0]         seconds_i,      // seconds
   input wire logic [7:0]         minute_i,       // minutes
   input wire logic               sec_carry_o,    // second carry
   input wire logic               rtc_tick_o,     // tick
   input wire logic               counter_run_o,  // run
   input wire logic               counter_hold_o, // hold
   input wire logic               clock_format_o, // 24h
   input wire logic               alarm_match_o   // alarm flag
);
   logic [PADDR_W-3:0] idx;    // register index
   logic               mapped; // address hits a register
   logic               ctl_wr; // control byte written
   int unsigned        gap;    // clocks since last tick
   logic               seen;   // tick seen since reset
   assign idx = paddr_i[PADDR_W-1:2];
   assign mapped = paddr_i[1:0] == 2'h0 && (idx inside {[`RCA_IDX_HOUR:`RCA_IDX_AL_WDAYS], `RCA_IDX_CTRL});
   assign ctl_wr = psel_i && penable_i && pwrite_i && pstrb_i[0] && mapped && idx == `RCA_IDX_CTRL;
   // tick spacing counter
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (rtc_tick_o) begin
         gap <= 0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);
   sequence s_ctl_wr;
      ctl_wr;
   endsequence
   chk_ready_high: assert property (pready_o)
      else $error("ready low");
   chk_err_decode: assert property (pslverr_o == (psel_i && penable_i && !mapped))
      else $error("error flag wrong");
   chk_read_upper: assert property (psel_i && penable_i && !pwrite_i |-> prdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_tick_gap: assert property (seen && rtc_tick_o |-> gap == RTC_DIV - 1)
      else $error("tick spacing wrong");
   chk_sec_on_tick: assert property (sec_carry_o |-> $past(rtc_tick_o) && $past(counter_run_o))
      else $error("second carry off tick");
   chk_fmt_write: assert property (s_ctl_wr |=> clock_format_o == $past(pwdata_i[3]))
      else $error("format bit not taken");
   chk_fmt_stable: assert property (!ctl_wr |=> $stable(clock_format_o))
      else $error("format changed alone");
   chk_run_write: assert property (s_ctl_wr |=> counter_run_o == $past(pwdata_i[0]))
      else $error("run bit not taken");
   chk_hold_write: assert property (s_ctl_wr |=> counter_hold_o == $past(pwdata_i[1]))
      else $error("hold bit not taken");
   chk_flag_tick: assert property ($rose(alarm_match_o) |-> $past(rtc_tick_o))
      else $error("alarm flag off tick");
endmodule
bind rca_calendar rca_calendar_assertions #(.PADDR_W(PADDR_W), .RTC_DIV(RTC_DIV)) rca_calendar_assertions_inst (
   .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
   .pslverr_o(pslverr_o), .minute_carry_i(minute_carry_i), .seconds_i(seconds_i), .minute_i(minute_i),
   .sec_carry_o(sec_carry_o), .rtc_tick_o(rtc_tick_o), .counter_run_o(counter_run_o),
   .counter_hold_o(counter_hold_o), .clock_format_o(clock_format_o), .alarm_match_o(alarm_match_o));

// ==== test/rca_calendar_test.sv ====
`timescale 1ns/1ps
`include "rca_consts.svh"
module rca_calendar_test;
   localparam int DIV = 2;       // short tick for simulation
   localparam int SET = 2*DIV+2; // clocks for a write to land
   logic        clock_i = 1'b0;  // clock
   logic        reset_i = 1'b1;  // reset
   logic        psel = 1'b0;     // select
   logic        penable = 1'b0;  // enable
   logic        pwrite = 1'b0;   // direction
   logic [21:0] paddr = 22'h0;   // address
   logic [31:0] pwdata = 32'h0;  // write data
   logic [3:0]  pstrb = 4'h0;    // strobes
   logic        carry = 1'b0;    // minute carry
   logic [7:0]  mins = 8'h00;    // minutes in
   logic [7:0]  secs = 8'h15;    // seconds in
   logic        pready, pslverr, sec_c, tick, run, hold, fmt, match;
   logic [31:0] prdata;          // read data
   logic [32:0] exq[$];          // expected error and data
   logic [7:0]  r;               // random byte
   int          num_errors = 0;  // mismatches
   int          num_checks = 0;  // comparisons
   int          nt = 0;          // run ticks
   int          seed = 32'h5DC9; // random seed
   logic [19:0] cidx [5] = '{`RCA_IDX_HOUR, `RCA_IDX_WDAY, `RCA_IDX_DAY, `RCA_IDX_MONTH, `RCA_IDX_YEAR};
   logic [7:0]  rstv [9] = '{8'h12, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h12, 8'h00};
   // control, hour..year before, hour..year after one carry
   logic [87:0] cal [10] = '{
      88'h01_11_02_15_06_23_32_02_15_06_23, 88'h01_32_01_10_01_50_21_01_10_01_50,
      88'h01_31_06_30_04_23_12_00_01_05_23, 88'h01_12_04_09_09_09_01_04_09_09_09,
      88'h09_09_02_14_07_07_10_02_14_07_07, 88'h09_23_01_30_11_10_00_02_01_12_10,
      88'h09_23_03_28_02_04_00_04_29_02_04, 88'h09_23_03_28_02_01_00_04_01_03_01,
      88'h09_23_05_29_02_00_00_06_01_03_00, 88'h09_23_06_31_12_99_00_00_01_01_00};
   always #10 clock_i = ~clock_i;
   rca_calendar #(.PADDR_W(22), .RTC_DIV(DIV)) rca_calendar_inst (
      .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .minute_carry_i(carry), .seconds_i(secs), .minute_i(mins),
      .sec_carry_o(sec_c), .rtc_tick_o(tick), .counter_run_o(run), .counter_hold_o(hold),
      .clock_format_o(fmt), .alarm_match_o(match));
   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // compare one read result
   task automatic check_read(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t read %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for a flag at a rising edge
   task automatic await(ref logic s, input int lim);
      int n;
      for (n = 0; n < lim && s !== 1'b1; n++) @(posedge clock_i);
      if (n == lim) begin
         num_errors++;
         $display("FAIL %0t wait timed out", $time);
         report_and_stop();
      end
   endtask
   // one apb transfer, idle cycle after
   task automatic apb(input logic w, input logic [19:0] i, input logic [7:0] d, input logic [3:0] s,
                      input logic [32:0] e);
      if (!w) exq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      await(pready, 16);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [19:0] i, input logic [7:0] d);
      apb(1'b1, i, d, 4'hF, 33'h0);
   endtask
   task automatic rd(input logic [19:0] i, input logic [7:0] e);
      apb(1'b0, i, 8'h0, 4'hF, {25'h0, e});
   endtask
   // minute carry pulse, then time to ripple
   task automatic pulse();
      carry <= 1'b1;
      @(posedge clock_i);
      carry <= 1'b0;
      repeat (SET + DIV) @(posedge clock_i);
   endtask
   // read monitor takes the oldest note
   always @(posedge clock_i) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         if (exq.size() == 0) begin
            num_errors++;
            $display("FAIL %0t unexpected read", $time);
         end else begin
            check_read({pslverr, prdata}, exq.pop_front());
         end
      end
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      for (int k = 0; k < 9; k++) rd(20'(20'hFFF94 + k), rstv[k]);
      rd(`RCA_IDX_CTRL, 8'h00);
      apb(1'b0, 20'hFFF9D, 8'h0, 4'hF, {1'b1, 32'h0}); // unmapped read refused
      wr(`RCA_IDX_CTRL, 8'h08);
      rd(`RCA_IDX_HOUR, 8'h00);
      rd(`RCA_IDX_AL_HOUR, 8'h00);
      wr(`RCA_IDX_HOUR, 8'h13);
      repeat (SET) @(posedge clock_i);
      wr(`RCA_IDX_CTRL, 8'h00);
      rd(`RCA_IDX_HOUR, 8'h21);
      wr(`RCA_IDX_CTRL, 8'h08);
      rd(`RCA_IDX_HOUR, 8'h13);
      r = 8'($random(seed));
      wr(`RCA_IDX_TRIM, r);
      apb(1'b1, `RCA_IDX_TRIM, ~r, 4'h0, 33'h0);
      rd(`RCA_IDX_TRIM, r);
      r = 8'($random(seed));
      wr(`RCA_IDX_AL_WDAYS, r);
      rd(`RCA_IDX_AL_WDAYS, {1'b0, r[6:0]});
      for (int i = 0; i < 10; i++) begin
         wr(`RCA_IDX_CTRL, cal[i][87:80]);
         for (int k = 0; k < 5; k++) wr(cidx[k], cal[i][79-8*k -: 8]);
         repeat (SET) @(posedge clock_i);
         pulse();
         for (int k = 0; k < 5; k++) rd(cidx[k], cal[i][39-8*k -: 8]);
      end
      wr(`RCA_IDX_CTRL, 8'h0B);
      wr(`RCA_IDX_HOUR, 8'h05);
      repeat (SET) @(posedge clock_i);
      pulse();
      rd(`RCA_IDX_HOUR, 8'h05);
      wr(`RCA_IDX_CTRL, 8'h09);
      repeat (SET) @(posedge clock_i);
      rd(`RCA_IDX_HOUR, 8'h06);
      wr(`RCA_IDX_DAY, 8'h10);
      wr(`RCA_IDX_HOUR, 8'h23);
      repeat (SET) @(posedge clock_i);
      await(tick, 8);
      fork
         wr(`RCA_IDX_HOUR, 8'h07);
         begin
            @(posedge clock_i);
            pulse();
         end
      join
      rd(`RCA_IDX_HOUR, 8'h07);
      rd(`RCA_IDX_DAY, 8'h10);
      wr(`RCA_IDX_WDAY, 8'h03);
      wr(`RCA_IDX_AL_MIN, 8'h30);
      wr(`RCA_IDX_AL_HOUR, 8'h07);
      wr(`RCA_IDX_AL_WDAYS, 8'h08);
      mins <= 8'h30;
      wr(`RCA_IDX_CTRL, 8'h0D);
      repeat (SET + DIV) @(posedge clock_i);
      rd(`RCA_IDX_CTRL, 8'h1D);
      wr(`RCA_IDX_CTRL, 8'h09);
      wr(`RCA_IDX_AL_MIN, 8'h60);
      mins <= 8'h60;
      wr(`RCA_IDX_CTRL, 8'h0D);
      repeat (SET + DIV) @(posedge clock_i);
      rd(`RCA_IDX_CTRL, 8'h0D);
      reset_i <= 1'b1;
      @(posedge clock_i);
      reset_i <= 1'b0;
      wr(`RCA_IDX_TRIM, 8'h7C);
      secs <= 8'h00;
      await(tick, 8);
      wr(`RCA_IDX_CTRL, 8'h01);
      while (sec_c !== 1'b1 && nt < 40000) begin
         @(posedge clock_i);
         if (tick === 1'b1) nt++;
      end
      check_read(33'(nt), 33'h7FF8);
      report_and_stop();
   end
endmodule
